// *** pdac_channel.sv ***
// DMA channel address stepping, direction, wrap restart and soft reset
// What this block does
// - Source pointer steps by the source mode on every beat, 00 increments, 01 reserved.
// - Destination mode 00 increments the destination pointer after each beat.
// - Destination mode 10 holds the destination pointer across beats.
// - Source mode 10 keeps the source pointer unchanged between beats.
// - Destination mode 11 reloads pointer and count at zero count and restarts.
// - Source mode 11 reloads pointer and count at zero count and restarts.
// - Wrap mode repeats until software clears the channel clock enable.
// - Clearing the enable finishes the active read and drops the staged word.
// - Writing 0 to the soft reset bit does nothing.
// - Writing 1 to the soft reset bit returns the state machine and pointers home.
`timescale 1ns/1ns
`include "pdac_consts.svh"
module pdac_channel
    import pdac_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // APB register slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire pdac_word_t pwdata,
    output pdac_word_t prdata,
    output logic pready,
    output logic pslverr,
    // Data mover master towards SRAM or peripherals
    output pdac_memreq_s memReq,
    input wire pdac_memrsp_s memRsp
);
    logic clkEn_r;
    pdac_mode_t dir_r;
    pdac_mode_t srcMode_r;
    pdac_mode_t dstMode_r;
    pdac_word_t srcBase_r;
    pdac_word_t dstBase_r;
    pdac_word_t progCnt_r;
    pdac_word_t curSrc_r;
    pdac_word_t curDst_r;
    pdac_word_t curCnt_r;
    pdac_word_t stage_r;
    pdac_word_t prdata_r;
    pdac_state_e state_r;
    pdac_state_e state_nxt;
    pdac_word_t curSrc_nxt;
    pdac_word_t curDst_nxt;
    pdac_word_t curCnt_nxt;
    pdac_word_t srcStep;
    pdac_word_t dstStep;

    // Address decode and access strobes
    wire logic setup = psel && !penable;
    wire logic wrAcc = psel && penable && pwrite;
    wire logic hitCtrl = (paddr == `PDAC_OFS_CTRL);
    wire logic hitSrcB = (paddr == `PDAC_OFS_SRCBASE);
    wire logic hitDstB = (paddr == `PDAC_OFS_DSTBASE);
    wire logic hitCnt = (paddr == `PDAC_OFS_COUNT);
    wire logic hitRo = (paddr == `PDAC_OFS_CURSRC) || (paddr == `PDAC_OFS_CURDST)
        || (paddr == `PDAC_OFS_CURCNT) || (paddr == `PDAC_OFS_STATUS);
    wire logic mapped = hitCtrl || hitSrcB || hitDstB || hitCnt || hitRo;
    wire logic wrCtrl = wrAcc && hitCtrl;
    // Zero wait states; any unmapped access or a write to a read-only offset answers with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && (!mapped || (pwrite && hitRo));
    assign prdata = prdata_r;

    // Software command strobes
    // zero is no command
    wire logic engine_soft_reset = wrCtrl && pwdata[`PDAC_BIT_SRST];
    wire logic startReq = wrCtrl && pwdata[`PDAC_BIT_START] && pwdata[`PDAC_BIT_CLKEN];

    // Beat handshakes and the last beat of a block
    wire logic rdDone = (state_r == PDAC_READ) && memRsp.ready;
    wire logic wrDone = (state_r == PDAC_WRITE) && memRsp.ready;
    wire logic lastBeat = (curCnt_r <= `PDAC_STEP_BYTES);
    wire logic anyWrap = (srcMode_r == `PDAC_MODE_WRAP) || (dstMode_r == `PDAC_MODE_WRAP);
    wire logic busy = (state_r != PDAC_IDLE);

    // Read and write side targets of each direction
    // direction picks the targets
    wire logic rdPeriph = (dir_r == `PDAC_DIR_P2M);
    wire logic wrPeriph = (dir_r == `PDAC_DIR_M2P);
    assign memReq.valid = busy;
    assign memReq.write = (state_r == PDAC_WRITE);
    assign memReq.periph = (state_r == PDAC_WRITE) ? wrPeriph : rdPeriph;
    assign memReq.addr = (state_r == PDAC_WRITE) ? curDst_r : curSrc_r;
    assign memReq.wdata = stage_r;

    // Source pointer stepping
    // source mode step
    pdac_addr_step srcStepper (
        .mode(srcMode_r),
        .cur(curSrc_r),
        .base(srcBase_r),
        .last(lastBeat),
        .nxt(srcStep)
    );

    // Destination pointer stepping
    // destination mode step
    pdac_addr_step dstStepper (
        .mode(dstMode_r),
        .cur(curDst_r),
        .base(dstBase_r),
        .last(lastBeat),
        .nxt(dstStep)
    );

    // Channel sequencer
    always_comb
    begin
        state_nxt = state_r;
        curSrc_nxt = curSrc_r;
        curDst_nxt = curDst_r;
        curCnt_nxt = curCnt_r;
        case (state_r)
            PDAC_IDLE:
            begin
                if (startReq)
                begin
                    curSrc_nxt = srcBase_r;
                    curDst_nxt = dstBase_r;
                    curCnt_nxt = progCnt_r;
                    state_nxt = PDAC_READ;
                end
            end
            PDAC_READ:
            begin
                if (rdDone)
                begin
                    state_nxt = clkEn_r ? PDAC_WRITE : PDAC_IDLE;
                end
            end
            PDAC_WRITE:
            begin
                if (wrDone)
                begin
                    curSrc_nxt = srcStep;
                    curDst_nxt = dstStep;
                    if (lastBeat)
                    begin
                        curCnt_nxt = anyWrap ? progCnt_r : `PDAC_RST_WORD;
                        state_nxt = (anyWrap && clkEn_r) ? PDAC_READ : PDAC_IDLE;
                    end
                    else
                    begin
                        curCnt_nxt = 32'(curCnt_r - `PDAC_STEP_BYTES);
                        state_nxt = clkEn_r ? PDAC_READ : PDAC_IDLE;
                    end
                end
            end
            default:
            begin
                state_nxt = PDAC_IDLE;
            end
        endcase
    end

    // Sequencer state and pointers; soft reset overrides any beat
    // pointers and state home
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= PDAC_IDLE;
            curSrc_r <= `PDAC_RST_WORD;
            curDst_r <= `PDAC_RST_WORD;
            curCnt_r <= `PDAC_RST_WORD;
        end
        else if (engine_soft_reset)
        begin
            state_r <= PDAC_IDLE;
            curSrc_r <= `PDAC_RST_WORD;
            curDst_r <= `PDAC_RST_WORD;
            curCnt_r <= `PDAC_RST_WORD;
        end
        else
        begin
            state_r <= state_nxt;
            curSrc_r <= curSrc_nxt;
            curDst_r <= curDst_nxt;
            curCnt_r <= curCnt_nxt;
        end
    end

    // Staging buffer holds one word between read and write
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            stage_r <= `PDAC_RST_WORD;
        else if (rdDone)
            stage_r <= memRsp.rdata;
    end

    // Software written configuration; soft reset bit is never stored
    // reset bit self clears
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            clkEn_r <= 1'b0;
            dir_r <= `PDAC_DIR_M2M;
            srcMode_r <= `PDAC_MODE_INC;
            dstMode_r <= `PDAC_MODE_INC;
        end
        else if (wrCtrl)
        begin
            clkEn_r <= pwdata[`PDAC_BIT_CLKEN];
            dir_r <= pwdata[`PDAC_LSB_DIR +: 2];
            srcMode_r <= pwdata[`PDAC_LSB_SRCMODE +: 2];
            dstMode_r <= pwdata[`PDAC_LSB_DSTMODE +: 2];
        end
    end

    // Base addresses and programmed count
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            srcBase_r <= `PDAC_RST_WORD;
            dstBase_r <= `PDAC_RST_WORD;
            progCnt_r <= `PDAC_RST_WORD;
        end
        else if (wrAcc)
        begin
            if (hitSrcB)
                srcBase_r <= pwdata;
            if (hitDstB)
                dstBase_r <= pwdata;
            if (hitCnt)
                progCnt_r <= pwdata;
        end
    end

    // Read mux, captured in the setup cycle so prdata is a flop
    wire pdac_word_t ctrlView = {24'h00_0000, dstMode_r, srcMode_r, dir_r, 1'b0, clkEn_r};
    wire pdac_word_t statView = {30'h0000_0000, state_r};
    wire pdac_word_t rdMux =
        hitCtrl ? ctrlView :
        hitSrcB ? srcBase_r :
        hitDstB ? dstBase_r :
        hitCnt ? progCnt_r :
        (paddr == `PDAC_OFS_CURSRC) ? curSrc_r :
        (paddr == `PDAC_OFS_CURDST) ? curDst_r :
        (paddr == `PDAC_OFS_CURCNT) ? curCnt_r :
        (paddr == `PDAC_OFS_STATUS) ? statView : `PDAC_RST_WORD;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            prdata_r <= `PDAC_RST_WORD;
        else if (setup && !pwrite)
            prdata_r <= rdMux;
    end

    // Checks on stepping, wrap, discard, direction and soft reset
    srcinc_step_a: assert property (@(posedge clk) disable iff (!nrst)
        wrDone && !engine_soft_reset && srcMode_r == `PDAC_MODE_INC
        |=> curSrc_r == $past(curSrc_r) + `PDAC_STEP_BYTES)
        else $error("source pointer did not increment");
    dstinc_step_a: assert property (@(posedge clk) disable iff (!nrst)
        wrDone && !engine_soft_reset && dstMode_r == `PDAC_MODE_INC
        |=> curDst_r == $past(curDst_r) + `PDAC_STEP_BYTES)
        else $error("destination pointer did not increment");
    dstfix_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        wrDone && !engine_soft_reset && dstMode_r == `PDAC_MODE_FIX |=> $stable(curDst_r))
        else $error("fixed destination pointer moved");
    srcfix_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        wrDone && !engine_soft_reset && srcMode_r == `PDAC_MODE_FIX |=> $stable(curSrc_r))
        else $error("fixed source pointer moved");
    dstwrap_reload_a: assert property (@(posedge clk) disable iff (!nrst)
        wrDone && !engine_soft_reset && lastBeat && dstMode_r == `PDAC_MODE_WRAP
        |=> curDst_r == $past(dstBase_r) && curCnt_r == $past(progCnt_r))
        else $error("destination wrap did not reload");
    srcwrap_reload_a: assert property (@(posedge clk) disable iff (!nrst)
        wrDone && !engine_soft_reset && lastBeat && srcMode_r == `PDAC_MODE_WRAP
        |=> curSrc_r == $past(srcBase_r) && curCnt_r == $past(progCnt_r))
        else $error("source wrap did not reload");
    wrap_restart_a: assert property (@(posedge clk) disable iff (!nrst)
        wrDone && !engine_soft_reset && lastBeat && anyWrap && clkEn_r |=> state_r == PDAC_READ)
        else $error("wrap block did not restart");
    stop_discard_a: assert property (@(posedge clk) disable iff (!nrst)
        rdDone && !engine_soft_reset && !clkEn_r |=> state_r == PDAC_IDLE ##1 !memReq.write)
        else $error("staged word written after disable");
    dir_target_a: assert property (@(posedge clk) disable iff (!nrst)
        memReq.valid |-> memReq.periph ==
        (memReq.write ? (dir_r == `PDAC_DIR_M2P) : (dir_r == `PDAC_DIR_P2M)))
        else $error("wrong target for direction");
    soft_reset_a: assert property (@(posedge clk) disable iff (!nrst)
        engine_soft_reset |=> state_r == PDAC_IDLE && curSrc_r == `PDAC_RST_WORD
        && curDst_r == `PDAC_RST_WORD)
        else $error("soft reset did not clear engine");
endmodule : pdac_channel

// *** pdac_consts.svh ***
// Offsets, field positions, reset values and step counts of the DMA channel control
`ifndef PDAC_CONSTS_SVH
`define PDAC_CONSTS_SVH
`define PDAC_OFS_CTRL 8'h00
`define PDAC_OFS_SRCBASE 8'h04
`define PDAC_OFS_DSTBASE 8'h08
`define PDAC_OFS_COUNT 8'h0C
`define PDAC_OFS_CURSRC 8'h10
`define PDAC_OFS_CURDST 8'h14
`define PDAC_OFS_CURCNT 8'h18
`define PDAC_OFS_STATUS 8'h1C
`define PDAC_BIT_CLKEN 0
`define PDAC_BIT_SRST 1
`define PDAC_LSB_DIR 2
`define PDAC_LSB_SRCMODE 4
`define PDAC_LSB_DSTMODE 6
`define PDAC_BIT_START 8
`define PDAC_RST_WORD 32'h0000_0000
`define PDAC_MODE_INC 2'h0
`define PDAC_MODE_RSVD 2'h1
`define PDAC_MODE_FIX 2'h2
`define PDAC_MODE_WRAP 2'h3
`define PDAC_DIR_M2M 2'h0
`define PDAC_DIR_P2M 2'h1
`define PDAC_DIR_M2P 2'h2
`define PDAC_STEP_BYTES 32'h0000_0004
`endif

// *** pdac_pkg.sv ***
// Types shared by the DMA channel control files
package pdac_pkg;
    typedef logic [31:0] pdac_word_t;
    typedef logic [1:0] pdac_mode_t;
    typedef enum logic [1:0] {PDAC_IDLE, PDAC_READ, PDAC_WRITE} pdac_state_e;
    // Request from the channel to SRAM or to an APB peripheral
    typedef struct packed {
        logic valid;
        logic write;
        logic periph;
        pdac_word_t addr;
        pdac_word_t wdata;
    } pdac_memreq_s;
    // Answer from the addressed target
    typedef struct packed {
        logic ready;
        pdac_word_t rdata;
    } pdac_memrsp_s;
endpackage : pdac_pkg

// *** pdac_addr_step.sv ***
// Next value of one current address pointer after a completed beat
`timescale 1ns/1ns
`include "pdac_consts.svh"
module pdac_addr_step
    import pdac_pkg::*;
(
    // Mode and pointer state
    input wire pdac_mode_t mode,
    input wire pdac_word_t cur,
    input wire pdac_word_t base,
    input wire logic last,
    // Pointer value for the next beat
    output pdac_word_t nxt
);
    // Wrap mode still steps inside a block; only the last beat reloads
    wire pdac_word_t stepped = 32'(cur + `PDAC_STEP_BYTES);
    wire logic isInc = (mode == `PDAC_MODE_INC);
    wire logic isWrap = (mode == `PDAC_MODE_WRAP);
    // Reserved and fixed codes both hold the pointer, so a bad code moves nothing
    assign nxt = (isWrap && last) ? base : ((isInc || isWrap) ? stepped : cur);
endmodule : pdac_addr_step

// *** pdac_mem_model.sv ***
// Behavioural SRAM and peripheral target facing the channel's data mover
`timescale 1ns/1ns
module pdac_mem_model
    import pdac_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Mover side
    input wire pdac_memreq_s memReq,
    output pdac_memrsp_s memRsp,
    // Wait control and log of the last write beat
    input wire logic [3:0] waitCycles,
    output pdac_word_t lastAddr,
    output pdac_word_t lastData,
    output logic lastPeriph,
    output logic [15:0] writeCount
);
    logic [3:0] waitCnt_r;
    pdac_word_t noise_r;
    pdac_word_t readWord;
    // Read word depends on address and target, so a wrong pointer shows up
    assign readWord = memReq.addr ^ (memReq.periph ? 32'hF0F0_0000 : 32'h5A5A_0000);
    // Answer after the wait count; noise otherwise so stale data never looks valid
    assign memRsp.ready = memReq.valid && (waitCnt_r == waitCycles);
    assign memRsp.rdata = memRsp.ready ? readWord : noise_r;
    // Wait counter and write log
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            waitCnt_r <= 4'h0;
            noise_r <= 32'h1234_5678;
            lastAddr <= 32'h0000_0000;
            lastData <= 32'h0000_0000;
            lastPeriph <= 1'b0;
            writeCount <= 16'h0000;
        end
        else
        begin
            noise_r <= noise_r + 32'h1357_9BDF;
            waitCnt_r <= (memReq.valid && !memRsp.ready) ? waitCnt_r + 4'h1 : 4'h0;
            if (memRsp.ready && memReq.write)
            begin
                lastAddr <= memReq.addr;
                lastData <= memReq.wdata;
                lastPeriph <= memReq.periph;
                writeCount <= writeCount + 16'h0001;
            end
        end
    end
endmodule : pdac_mem_model

// *** pdac_channel_test.sv ***
// Self-checking bench for the DMA channel control block
`timescale 1ns/1ns
`include "pdac_consts.svh"
module pdac_channel_test
    import pdac_pkg::*;
;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, lastPeriph, errSeen;
    logic [7:0] paddr;
    logic [3:0] waitCycles;
    logic [15:0] writeCount;
    pdac_word_t pwdata, prdata, lastAddr, lastData;
    pdac_memreq_s memReq;
    pdac_memrsp_s memRsp;
    int fails;
    int checked;
    pdac_channel dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .memReq, .memRsp);
    pdac_mem_model target (.clk, .nrst, .memReq, .memRsp, .waitCycles, .lastAddr,
        .lastData, .lastPeriph, .writeCount);
    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string what, input pdac_word_t exp, input pdac_word_t got);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic conclude;
        $display("Comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic stuck(input string what);
        fails++;
        $display("CHECK FAILED %s expected done seen timeout", what);
        conclude();
    endtask : stuck
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input pdac_word_t d,
        output pdac_word_t q);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            stuck("apb ready");
        q = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic pdac_word_t ctrl(input logic en, sr, st, input pdac_mode_t dir, sm, dm);
        pdac_word_t w;
        w = `PDAC_RST_WORD;
        w[`PDAC_BIT_CLKEN] = en;
        w[`PDAC_BIT_SRST] = sr;
        w[`PDAC_BIT_START] = st;
        w[`PDAC_LSB_DIR +: 2] = dir;
        w[`PDAC_LSB_SRCMODE +: 2] = sm;
        w[`PDAC_LSB_DSTMODE +: 2] = dm;
        return w;
    endfunction : ctrl
    function automatic pdac_word_t rv(input pdac_word_t a, input logic p);
        return a ^ (p ? 32'hF0F0_0000 : 32'h5A5A_0000);
    endfunction : rv
    // Status polling bounds the wait for idle; waitWrites bounds its wait at 2000 clocks
    task automatic waitIdle;
        pdac_word_t s;
        int n;
        n = 0;
        do
        begin
            apb(1'b0, `PDAC_OFS_STATUS, 32'h0, s);
            n++;
        end
        while (s !== 32'h0 && n < 300);
        if (s !== 32'h0)
            stuck("idle");
    endtask : waitIdle
    task automatic waitWrites(input logic [15:0] k);
        int n;
        for (n = 0; n < 2000 && writeCount < k; n++)
            @(posedge clk);
        if (writeCount < k)
            stuck("write beats");
    endtask : waitWrites
    task automatic setup(input pdac_word_t cnt, input logic [3:0] wt, input pdac_word_t c);
        pdac_word_t q;
        waitCycles <= wt;
        apb(1'b1, `PDAC_OFS_SRCBASE, 32'h0000_1000, q);
        apb(1'b1, `PDAC_OFS_DSTBASE, 32'h0000_2000, q);
        apb(1'b1, `PDAC_OFS_COUNT, cnt, q);
        apb(1'b1, `PDAC_OFS_CTRL, c, q);
    endtask : setup
    task automatic scnReset;
        pdac_word_t q;
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0, q);
            chk("reset value", `PDAC_RST_WORD, q);
        end
        apb(1'b0, 8'h20, 32'h0, q);
        chk("unmapped error", 32'h1, {31'h0, errSeen});
    endtask : scnReset
    // Whole transfer, then last beat and final pointers against the modes
    task automatic scnRun(input pdac_mode_t dir, sm, dm, input pdac_word_t cnt,
        input logic [3:0] wt);
        pdac_word_t q, n, st;
        logic [15:0] w0;
        n = cnt >> 2;
        st = `PDAC_STEP_BYTES;
        w0 = writeCount;
        setup(cnt, wt, ctrl(1'b1, 1'b0, 1'b1, dir, sm, dm));
        waitIdle();
        chk("beats", n, 32'(writeCount - w0));
        chk("last dst", 32'h2000 + (dm == `PDAC_MODE_INC ? st * (n - 1) : 0),
            lastAddr);
        chk("last data", rv(32'h1000 + (sm == `PDAC_MODE_INC ? st * (n - 1) : 0),
            dir == `PDAC_DIR_P2M), lastData);
        chk("dst periph", 32'(dir == `PDAC_DIR_M2P), {31'h0, lastPeriph});
        apb(1'b0, `PDAC_OFS_CURSRC, 32'h0, q);
        chk("cur src", 32'h1000 + (sm == `PDAC_MODE_INC ? st * n : 0), q);
        apb(1'b0, `PDAC_OFS_CURDST, 32'h0, q);
        chk("cur dst", 32'h2000 + (dm == `PDAC_MODE_INC ? st * n : 0), q);
    endtask : scnRun
    // Two-beat wrap, stopped mid-read of the second pass; slow target so the stop lands in a read
    task automatic scnWrap(input pdac_mode_t sm, dm);
        pdac_word_t q;
        logic [15:0] w0;
        w0 = writeCount;
        setup(32'h8, 4'h6, ctrl(1'b1, 1'b0, 1'b1, `PDAC_DIR_M2M, sm, dm));
        waitWrites(w0 + 16'h3);
        apb(1'b1, `PDAC_OFS_CTRL, ctrl(1'b0, 1'b0, 1'b0, `PDAC_DIR_M2M, sm, dm), q);
        waitIdle();
        chk("wrap writes", 32'h3, 32'(writeCount - w0));
        chk("wrap dst", dm == `PDAC_MODE_WRAP ? 32'h2000 : 32'h2008, lastAddr);
        chk("wrap data", rv(sm == `PDAC_MODE_WRAP ? 32'h1000 : 32'h1008, 1'b0),
            lastData);
        apb(1'b0, `PDAC_OFS_CURCNT, 32'h0, q);
        chk("count reload", 32'h4, q);
    endtask : scnWrap
    task automatic scnSoft;
        pdac_word_t q;
        setup(32'h40, 4'h6, ctrl(1'b1, 1'b0, 1'b1, `PDAC_DIR_M2P, 2'h0, 2'h0));
        waitWrites(writeCount + 16'h1);
        apb(1'b1, `PDAC_OFS_CTRL, ctrl(1'b1, 1'b0, 1'b0, `PDAC_DIR_M2P, 2'h0, 2'h0), q);
        apb(1'b0, `PDAC_OFS_STATUS, 32'h0, q);
        chk("busy", 32'h1, 32'(q != 32'h0));
        apb(1'b1, `PDAC_OFS_CTRL, ctrl(1'b1, 1'b1, 1'b0, `PDAC_DIR_M2P, 2'h2, 2'h0), q);
        for (int i = 4; i < 8; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0, q);
            chk("soft reset state", 32'h0, q);
        end
        chk("mover idle", 32'h0, {31'h0, memReq.valid});
        apb(1'b0, `PDAC_OFS_CTRL, 32'h0, q);
        chk("ctrl readback", ctrl(1'b1, 1'b0, 1'b0, `PDAC_DIR_M2P, 2'h2, 2'h0), q);
    endtask : scnSoft
    // Main sequence
    initial
    begin
        nrst = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        waitCycles = 4'h0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        scnReset();
        scnRun(`PDAC_DIR_M2M, `PDAC_MODE_INC, `PDAC_MODE_INC, 32'h10, 4'h0);
        scnRun(`PDAC_DIR_P2M, `PDAC_MODE_FIX, `PDAC_MODE_INC, 32'h0C, 4'h2);
        scnRun(`PDAC_DIR_M2P, `PDAC_MODE_INC, `PDAC_MODE_FIX, 32'h04, 4'h1);
        scnRun(`PDAC_DIR_M2M, `PDAC_MODE_RSVD, `PDAC_MODE_RSVD, 32'h08, 4'h0);
        scnWrap(`PDAC_MODE_INC, `PDAC_MODE_WRAP);
        scnWrap(`PDAC_MODE_WRAP, `PDAC_MODE_INC);
        scnSoft();
        conclude();
    end
endmodule : pdac_channel_test
